// ===== fsr_pkg.sv
// Package for the fault status and reporting register bank
package fsr_pkg;

  // Register offsets
  localparam logic [7:0] FSR_CHANNEL_OUTPUT_FAULTS_OFS  = 8'h70;
  localparam logic [7:0] FSR_DEV_FAULT_A_OFS = 8'h71;
  localparam logic [7:0] FSR_DEV_FAULT_B_OFS = 8'h72;
  localparam logic [7:0] FSR_THERM_WARN_OFS  = 8'h73;
  localparam logic [7:0] FSR_REPORT_MASK_OFS = 8'h74;
  localparam logic [7:0] FSR_LATCH_CFG_OFS   = 8'h75;
  localparam logic [7:0] FSR_RECOVER_CFG_OFS = 8'h76;
  localparam logic [7:0] FSR_ERR_RESET_OFS   = 8'h78;

  // Reset values
  localparam logic [7:0] FSR_REPORT_MASK_RST = 8'h00;
  localparam logic [7:0] FSR_LATCH_CFG_RST   = 8'hF8;
  localparam logic [7:0] FSR_RECOVER_CFG_RST = 8'h00;

  // Channel fault register fields
  localparam int FSR_LEFT_DC_BIT   = 3;
  localparam int FSR_RIGHT_DC_BIT  = 2;
  localparam int FSR_LEFT_OC_BIT   = 1;
  localparam int FSR_RIGHT_OC_BIT  = 0;
  // Device fault A fields
  localparam int FSR_CRC_ERR_BIT   = 7;
  localparam int FSR_BQ_FAIL_BIT   = 6;
  localparam int FSR_CLK_FLT_BIT   = 2;
  localparam int FSR_PS_OV_BIT     = 1;
  localparam int FSR_PS_UV_BIT     = 0;
  // Device fault B and warning fields
  localparam int FSR_TSD_BIT       = 0;
  localparam int FSR_TWARN_BIT     = 2;
  // Report mask fields
  localparam int FSR_M_TSD_BIT     = 7;
  localparam int FSR_M_DS_UV_BIT   = 6;
  localparam int FSR_M_DS_OV_BIT   = 5;
  localparam int FSR_M_CLK_BIT     = 4;
  localparam int FSR_M_PS_UV_BIT   = 3;
  localparam int FSR_M_PS_OV_BIT   = 2;
  localparam int FSR_M_DC_BIT      = 1;
  localparam int FSR_M_OC_BIT      = 0;
  // Latch config fields
  localparam int FSR_H_CLK_BIT     = 5;
  localparam int FSR_H_TSD_BIT     = 4;
  localparam int FSR_H_TWARN_BIT   = 3;
  localparam int FSR_M_TWARN_BIT   = 2;
  // Recovery config fields
  localparam int FSR_DET_HOLD_BIT  = 7;
  localparam int FSR_AUTO_REC_BIT  = 4;
  // Error reset command field
  localparam int FSR_CLEAR_BIT     = 7;

  // Number of raw detector inputs
  localparam int FSR_NDET = 12;

  // Raw detector indications from the analog side
  typedef struct packed {
    logic left_dc;
    logic right_dc;
    logic left_oc;
    logic right_oc;
    logic crc_err;
    logic bq_fail;
    logic clk_flt;
    logic ps_over;
    logic ps_under;
    logic ds_over;
    logic ds_under;
    logic tsd;
  } fsr_det_t;

  // Register access port
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fsr_req_t;

endpackage

// ===== fsr_sync.sv
// Three-stage synchroniser with agreement filter, one per bit
`timescale 1ns/1ps
`default_nettype none
module fsr_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Asynchronous inputs and filtered result
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      // Each bit owns its stages, so no vector has two writing processes
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic out_q;

      always_ff @(posedge clk) begin
        if (rst) begin
          s1_q  <= 1'b0;
          s2_q  <= 1'b0;
          s3_q  <= 1'b0;
          out_q <= 1'b0;
        end else begin
          s1_q <= async_in[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
          // Change counts only once stages two and three agree
          if (s2_q == s3_q) begin
            out_q <= s3_q;
          end
        end
      end

      assign sync_out[g] = out_q;
    end
  endgenerate

endmodule // fsr_sync
`default_nettype wire

// ===== fsr_regs.sv
// Fault status, masking, latching and recovery register bank
//
// Summary of operation
// - Left DC fault shows in channel bit 3, right DC in bit 2
// - Left overcurrent shows in channel bit 1, right in bit 0
// - Memory CRC mismatch sets bit 7 of device fault A
// - Failed biquad coefficient write sets bit 6 of device fault A
// - Thermal shutdown in bit 0 of device fault B, rest read zero
// - Thermal warning at 135C shows in bit 2 of warning register
// - Mask bits 7,6,5 suppress thermal, logic supply under/over reports
// - Mask bits 4,3,2 suppress clock, power supply under/over reports
// - Mask bits 1,0 suppress DC and overcurrent reports; reset unmasked
// - Latch config bit 2 suppresses thermal warning report; resets 0
// - Latch config bit 5 (reset 1) holds clock fault latched
// - Latch config bit 4 (reset 1) holds thermal shutdown latched
// - Latch config bit 3 (reset 1) holds thermal warning latched
// - Recovery bit 7 latches clock detect status, else follows live
// - Recovery bit 4 enables thermal auto recovery; resets disabled
// - Writing 1 to clear bit 7 clears latched analog faults
`timescale 1ns/1ps
`default_nettype none
module fsr_regs
  import fsr_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Register access
  input  wire fsr_req_t         req,
  output logic      [7:0]       rdata,
  output logic                  rvalid,
  // Raw analog detector indications
  input  wire fsr_det_t         det,
  input  wire logic             therm_warn_raw,
  input  wire logic             clk_detect_raw,
  // Reports and controls
  output logic                  fault_report,
  output logic                  warn_report,
  output logic                  clk_detect_status,
  output logic                  thermal_shutdown_active,
  output logic                  thermal_auto_recover_enable
);

  // Synchronised detectors; they come from the analog domain
  logic [FSR_NDET+1:0] raw_vec;
  logic [FSR_NDET+1:0] syn_vec;
  fsr_det_t            d;
  logic                twarn_live;
  logic                cdet_live;

  assign raw_vec = {det, therm_warn_raw, clk_detect_raw};

  fsr_sync #(
    .W (FSR_NDET + 2)
  ) u_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in (raw_vec),
    .sync_out (syn_vec)
  );

  assign d          = fsr_det_t'(syn_vec[FSR_NDET+1:2]);
  assign twarn_live = syn_vec[1];
  assign cdet_live  = syn_vec[0];

  // Software registers
  logic [7:0] mask_q;
  logic [7:0] latch_cfg_q;
  logic [7:0] recover_cfg_q;
  logic       clear_cmd;

  assign clear_cmd = req.wr && (req.addr == FSR_ERR_RESET_OFS)
                     && req.wdata[FSR_CLEAR_BIT];

  always_ff @(posedge clk) begin
    if (rst) begin
      mask_q        <= FSR_REPORT_MASK_RST;
      latch_cfg_q   <= FSR_LATCH_CFG_RST;
      recover_cfg_q <= FSR_RECOVER_CFG_RST;
    end else if (req.wr) begin
      case (req.addr)
        FSR_REPORT_MASK_OFS: mask_q        <= req.wdata;
        FSR_LATCH_CFG_OFS:   latch_cfg_q   <= req.wdata;
        FSR_RECOVER_CFG_OFS: recover_cfg_q <= req.wdata;
        default: ;
      endcase
    end
  end

  logic hold_clk;
  logic hold_tsd;
  logic hold_twarn;
  logic det_hold;
  logic auto_rec;

  assign hold_clk   = latch_cfg_q[FSR_H_CLK_BIT];
  assign hold_tsd   = latch_cfg_q[FSR_H_TSD_BIT];
  assign hold_twarn = latch_cfg_q[FSR_H_TWARN_BIT];
  assign det_hold   = recover_cfg_q[FSR_DET_HOLD_BIT];
  assign auto_rec   = recover_cfg_q[FSR_AUTO_REC_BIT];

  // Fault status. Sticky flags: a new event wins over a clear.
  logic [3:0] chan_q;
  logic [4:0] deva_q;
  logic       tsd_q;
  logic       twarn_q;
  logic       ds_ov_q;
  logic       ds_uv_q;
  logic       cdet_q;

  // Channel and supply faults latch until cleared; the analog side
  // keeps them asserted while the condition persists anyway
  always_ff @(posedge clk) begin
    if (rst) begin
      chan_q <= 4'h0;
    end else begin
      chan_q[FSR_LEFT_DC_BIT]  <= d.left_dc
        | (chan_q[FSR_LEFT_DC_BIT] & ~clear_cmd);
      chan_q[FSR_RIGHT_DC_BIT] <= d.right_dc
        | (chan_q[FSR_RIGHT_DC_BIT] & ~clear_cmd);
      chan_q[FSR_LEFT_OC_BIT]  <= d.left_oc
        | (chan_q[FSR_LEFT_OC_BIT] & ~clear_cmd);
      chan_q[FSR_RIGHT_OC_BIT] <= d.right_oc
        | (chan_q[FSR_RIGHT_OC_BIT] & ~clear_cmd);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      deva_q  <= 5'h00;
      ds_ov_q <= 1'b0;
      ds_uv_q <= 1'b0;
    end else begin
      deva_q[4] <= d.crc_err | (deva_q[4] & ~clear_cmd);
      deva_q[3] <= d.bq_fail | (deva_q[3] & ~clear_cmd);
      // Clock fault follows the live detector unless held
      deva_q[2] <= d.clk_flt
        | (deva_q[2] & hold_clk & ~clear_cmd);
      deva_q[1] <= d.ps_over | (deva_q[1] & ~clear_cmd);
      deva_q[0] <= d.ps_under | (deva_q[0] & ~clear_cmd);
      ds_ov_q   <= d.ds_over | (ds_ov_q & ~clear_cmd);
      ds_uv_q   <= d.ds_under | (ds_uv_q & ~clear_cmd);
    end
  end

  // Thermal shutdown: held if enabled; auto recovery drops it once the
  // condition clears even while held, so the stage can restart
  always_ff @(posedge clk) begin
    if (rst) begin
      tsd_q <= 1'b0;
    end else if (d.tsd) begin
      tsd_q <= 1'b1;
    end else if (auto_rec) begin
      tsd_q <= 1'b0;
    end else if (!hold_tsd || clear_cmd) begin
      tsd_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      twarn_q <= 1'b0;
    end else if (twarn_live) begin
      twarn_q <= 1'b1;
    end else if (!hold_twarn || clear_cmd) begin
      twarn_q <= 1'b0;
    end
  end

  // Clock detection status, latched or live
  always_ff @(posedge clk) begin
    if (rst) begin
      cdet_q <= 1'b0;
    end else if (cdet_live) begin
      cdet_q <= 1'b1;
    end else if (!det_hold || clear_cmd) begin
      cdet_q <= 1'b0;
    end
  end

  // Register read, registered one cycle after the request
  logic [7:0] rd_d;

  always_comb begin
    rd_d = 8'h00;
    case (req.addr)
      FSR_CHANNEL_OUTPUT_FAULTS_OFS:  rd_d = {4'h0, chan_q};
      FSR_DEV_FAULT_A_OFS: rd_d = {deva_q[4:3], 3'h0, deva_q[2:0]};
      FSR_DEV_FAULT_B_OFS: rd_d = {7'h00, tsd_q};
      FSR_THERM_WARN_OFS:  rd_d = {5'h00, twarn_q, 2'h0};
      FSR_REPORT_MASK_OFS: rd_d = mask_q;
      FSR_LATCH_CFG_OFS:   rd_d = latch_cfg_q;
      FSR_RECOVER_CFG_OFS: rd_d = recover_cfg_q;
      default:             rd_d = 8'h00;
    endcase
  end

  logic [7:0] rdata_q;
  logic       rvalid_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= req.rd;
      rdata_q  <= req.rd ? rd_d : 8'h00;
    end
  end

  // External reports, gated by masks only
  logic [7:0] rep_vec;
  logic       fault_d;
  logic       warn_d;

  assign rep_vec[FSR_M_TSD_BIT]   = tsd_q;
  assign rep_vec[FSR_M_DS_UV_BIT] = ds_uv_q;
  assign rep_vec[FSR_M_DS_OV_BIT] = ds_ov_q;
  assign rep_vec[FSR_M_CLK_BIT]   = deva_q[2];
  assign rep_vec[FSR_M_PS_UV_BIT] = deva_q[0];
  assign rep_vec[FSR_M_PS_OV_BIT] = deva_q[1];
  assign rep_vec[FSR_M_DC_BIT]    = chan_q[3] | chan_q[2];
  assign rep_vec[FSR_M_OC_BIT]    = chan_q[1] | chan_q[0];

  assign fault_d = |(rep_vec & ~mask_q);
  assign warn_d  = twarn_q & ~latch_cfg_q[FSR_M_TWARN_BIT];

  logic fault_q;
  logic warn_q;
  logic tsd_out_q;
  logic cdet_out_q;
  logic auto_out_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      fault_q    <= 1'b0;
      warn_q     <= 1'b0;
      tsd_out_q  <= 1'b0;
      cdet_out_q <= 1'b0;
      auto_out_q <= 1'b0;
    end else begin
      fault_q    <= fault_d;
      warn_q     <= warn_d;
      tsd_out_q  <= tsd_q;
      cdet_out_q <= cdet_q;
      auto_out_q <= auto_rec;
    end
  end

  assign rdata                       = rdata_q;
  assign rvalid                      = rvalid_q;
  assign fault_report                = fault_q;
  assign warn_report                 = warn_q;
  assign thermal_shutdown_active     = tsd_out_q;
  assign clk_detect_status           = cdet_out_q;
  assign thermal_auto_recover_enable = auto_out_q;

  // Checks
  property p_mask_gate;
    @(posedge clk) disable iff (rst)
      (mask_q == 8'hFF) |=> !fault_report;
  endproperty
  mask_gates_report_a: assert property (p_mask_gate)
    else $error("fault reported while fully masked");

  status_keeps_fault_a: assert property (
    @(posedge clk) disable iff (rst)
    (d.left_dc && mask_q[FSR_M_DC_BIT]) |=> chan_q[FSR_LEFT_DC_BIT])
    else $error("masked DC fault missing from status");

  right_oc_status_a: assert property (
    @(posedge clk) disable iff (rst)
    d.right_oc |=> chan_q[FSR_RIGHT_OC_BIT])
    else $error("right overcurrent not flagged");

  clk_live_track_a: assert property (
    @(posedge clk) disable iff (rst)
    (!hold_clk && !d.clk_flt) |=> !deva_q[2])
    else $error("unheld clock fault did not follow detector");

  sequence s_tsd_set;
    d.tsd ##1 tsd_q;
  endsequence
  sequence s_tsd_held;
    !d.tsd && hold_tsd && !auto_rec && !clear_cmd;
  endsequence
  tsd_hold_a: assert property (
    @(posedge clk) disable iff (rst)
    s_tsd_set ##0 s_tsd_held |=> tsd_q)
    else $error("thermal shutdown not held");

  auto_recover_a: assert property (
    @(posedge clk) disable iff (rst)
    (tsd_q && !d.tsd && auto_rec) |=> !tsd_q)
    else $error("auto recovery did not release shutdown");

  clear_latched_a: assert property (
    @(posedge clk) disable iff (rst)
    (clear_cmd && !d.crc_err) |=> !deva_q[4])
    else $error("clear command left CRC error set");

  warn_mask_a: assert property (
    @(posedge clk) disable iff (rst)
    latch_cfg_q[FSR_M_TWARN_BIT] |=> !warn_report)
    else $error("masked warning reported");

  cdet_live_a: assert property (
    @(posedge clk) disable iff (rst)
    (!det_hold && !cdet_live) |=> ##1 !clk_detect_status)
    else $error("clock detect not following live input");

  clk_fault_hold_a: assert property (
    @(posedge clk) disable iff (rst)
    (deva_q[2] && hold_clk && !clear_cmd) |=> deva_q[2])
    else $error("held clock fault dropped");

  warn_hold_a: assert property (
    @(posedge clk) disable iff (rst)
    (twarn_q && hold_twarn && !clear_cmd) |=> twarn_q)
    else $error("held thermal warning dropped");

  cdet_hold_a: assert property (
    @(posedge clk) disable iff (rst)
    (cdet_q && det_hold && !clear_cmd) |=> cdet_q)
    else $error("held clock detect status dropped");

  warn_report_a: assert property (
    @(posedge clk) disable iff (rst)
    (twarn_q && !latch_cfg_q[FSR_M_TWARN_BIT]) |=> warn_report)
    else $error("unmasked warning not reported");

  clk_report_a: assert property (
    @(posedge clk) disable iff (rst)
    (deva_q[2] && !mask_q[FSR_M_CLK_BIT]) |=> fault_report)
    else $error("unmasked clock fault not reported");

  // Decoded here again, apart from clear_cmd, so a broken decode shows
  sequence s_clear_write;
    req.wr && (req.addr == FSR_ERR_RESET_OFS) && req.wdata[FSR_CLEAR_BIT];
  endsequence
  sequence s_dc_gone;
    !d.left_dc && !d.right_dc;
  endsequence
  dc_clear_a: assert property (
    @(posedge clk) disable iff (rst)
    s_clear_write ##0 s_dc_gone
      |=> (!chan_q[FSR_LEFT_DC_BIT] && !chan_q[FSR_RIGHT_DC_BIT]))
    else $error("clear command left DC fault set");

  devb_reserved_a: assert property (
    @(posedge clk) disable iff (rst)
    (req.rd && (req.addr == FSR_DEV_FAULT_B_OFS))
      |=> (rvalid && (rdata[7:1] == 7'h00)))
    else $error("reserved shutdown register bits not zero");

  mask_write_a: assert property (
    @(posedge clk) disable iff (rst)
    (req.wr && (req.addr == FSR_REPORT_MASK_OFS))
      |=> (mask_q == $past(req.wdata)))
    else $error("mask write not taken");

endmodule // fsr_regs
`default_nettype wire

// ===== test_fault_status_and_reporting_regs.sv
// Self-checking testbench for the fault status register bank
`timescale 1ns/1ps
`default_nettype none
module test_fault_status_and_reporting_regs
  import fsr_pkg::*;
;
  logic       clk;
  logic       rst;
  fsr_req_t   req;
  logic [7:0] rdata;
  logic       rvalid;
  fsr_det_t   det;
  logic       therm_warn_raw;
  logic       clk_detect_raw;
  logic       fault_report;
  logic       warn_report;
  logic       clk_detect_status;
  logic       thermal_shutdown_active;
  logic       thermal_auto_recover_enable;
  int         bad_count;
  int         checks_done;

  // Per fault: detector, status offset, status value, mask (0 if none)
  localparam logic [11:0] DV [12] = '{12'h800, 12'h400, 12'h200, 12'h100,
    12'h080, 12'h040, 12'h020, 12'h010, 12'h008, 12'h004, 12'h002, 12'h001};
  localparam logic [7:0] AD [12] = '{8'h70, 8'h70, 8'h70, 8'h70, 8'h71,
    8'h71, 8'h71, 8'h71, 8'h71, 8'h71, 8'h71, 8'h72};
  localparam logic [7:0] EX [12] = '{8'h08, 8'h04, 8'h02, 8'h01, 8'h80,
    8'h40, 8'h04, 8'h02, 8'h01, 8'h00, 8'h00, 8'h01};
  localparam logic [7:0] MK [12] = '{8'h02, 8'h02, 8'h01, 8'h01, 8'h00,
    8'h00, 8'h10, 8'h04, 8'h08, 8'h20, 8'h40, 8'h80};

  fsr_regs uut (
    .clk                         (clk),
    .rst                         (rst),
    .req                         (req),
    .rdata                       (rdata),
    .rvalid                      (rvalid),
    .det                         (det),
    .therm_warn_raw              (therm_warn_raw),
    .clk_detect_raw              (clk_detect_raw),
    .fault_report                (fault_report),
    .warn_report                 (warn_report),
    .clk_detect_status           (clk_detect_status),
    .thermal_shutdown_active     (thermal_shutdown_active),
    .thermal_auto_recover_enable (thermal_auto_recover_enable)
  );

  always #12.5 clk = ~clk;

  task automatic test_done();
    if (bad_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  // Read data is taken in the cycle rvalid shows, since it stands one cycle
  task automatic rc(input string nm, input logic [7:0] a,
                    input logic [7:0] exp);
    int n;
    @(posedge clk);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge clk);
    req.rd <= 1'b0;
    n = 0;
    #1;
    while (rvalid !== 1'b1 && n < 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (rvalid !== 1'b1) begin
      bad_count++;
      $display("BAD rvalid expected 1 seen %b", rvalid);
      test_done();
    end else begin
      check(nm, rdata, exp);
    end
  endtask

  task automatic t_reset();
    rc("mask", FSR_REPORT_MASK_OFS, 8'h00);
    rc("latch", FSR_LATCH_CFG_OFS, 8'hF8);
    rc("recover", FSR_RECOVER_CFG_OFS, 8'h00);
    rc("devb", FSR_DEV_FAULT_B_OFS, 8'h00);
    rc("warn", FSR_THERM_WARN_OFS, 8'h00);
    rc("clear", FSR_ERR_RESET_OFS, 8'h00);
    reg_wr(FSR_CHANNEL_OUTPUT_FAULTS_OFS, 8'hFF);
    reg_wr(8'h77, 8'hFF);
    rc("ro chan", FSR_CHANNEL_OUTPUT_FAULTS_OFS, 8'h00);
    rc("unmapped", 8'h77, 8'h00);
    check("report", {7'h00, fault_report}, 8'h00);
  endtask

  // k is the fault's own mask bit, zero where the fault is never reported
  task automatic fault_pass(input logic [11:0] v, input logic [7:0] a,
                            input logic [7:0] e, input logic [7:0] m,
                            input logic [7:0] k);
    reg_wr(FSR_REPORT_MASK_OFS, m);
    det <= fsr_det_t'(v);
    cyc(8);
    rc("status", a, e);
    check("report", {7'h00, fault_report},
          {7'h00, (k != 8'h00) && ((m & k) == 8'h00)});
    @(posedge clk);
    det <= '0;
    cyc(8);
    rc("held", a, e);
    reg_wr(FSR_ERR_RESET_OFS, 8'h80);
    cyc(8);
    rc("cleared", a, 8'h00);
    check("report off", {7'h00, fault_report}, 8'h00);
  endtask

  task automatic t_faults();
    for (int i = 0; i < 12; i++) begin
      fault_pass(DV[i], AD[i], EX[i], 8'h00, MK[i]);
      if (MK[i] != 8'h00) begin
        fault_pass(DV[i], AD[i], EX[i], MK[i], MK[i]);
      end
    end
    reg_wr(FSR_REPORT_MASK_OFS, 8'h00);
  endtask

  task automatic t_warn();
    @(posedge clk);
    therm_warn_raw <= 1'b1;
    cyc(8);
    rc("warn", FSR_THERM_WARN_OFS, 8'h04);
    check("warn rpt", {7'h00, warn_report}, 8'h01);
    @(posedge clk);
    therm_warn_raw <= 1'b0;
    cyc(8);
    rc("warn held", FSR_THERM_WARN_OFS, 8'h04);
    reg_wr(FSR_ERR_RESET_OFS, 8'h80);
    cyc(8);
    rc("warn clr", FSR_THERM_WARN_OFS, 8'h00);
    reg_wr(FSR_LATCH_CFG_OFS, 8'hF4);
    therm_warn_raw <= 1'b1;
    cyc(8);
    rc("warn live", FSR_THERM_WARN_OFS, 8'h04);
    check("warn mask", {7'h00, warn_report}, 8'h00);
    @(posedge clk);
    therm_warn_raw <= 1'b0;
    cyc(8);
    rc("warn off", FSR_THERM_WARN_OFS, 8'h00);
    reg_wr(FSR_LATCH_CFG_OFS, 8'hF8);
  endtask

  task automatic t_live(input logic [7:0] cfg, input logic [11:0] v,
                        input logic [7:0] a, input logic [7:0] e);
    reg_wr(FSR_LATCH_CFG_OFS, cfg);
    rc("cfg", FSR_LATCH_CFG_OFS, cfg);
    @(posedge clk);
    det <= fsr_det_t'(v);
    cyc(8);
    rc("live on", a, e);
    @(posedge clk);
    det <= '0;
    cyc(8);
    rc("live off", a, 8'h00);
    reg_wr(FSR_LATCH_CFG_OFS, 8'hF8);
  endtask

  task automatic t_recover();
    reg_wr(FSR_RECOVER_CFG_OFS, 8'h10);
    rc("recover", FSR_RECOVER_CFG_OFS, 8'h10);
    check("auto en", {7'h00, thermal_auto_recover_enable}, 8'h01);
    @(posedge clk);
    det <= fsr_det_t'(12'h001);
    cyc(8);
    check("tsd on", {7'h00, thermal_shutdown_active}, 8'h01);
    @(posedge clk);
    det <= '0;
    cyc(8);
    check("tsd off", {7'h00, thermal_shutdown_active}, 8'h00);
    rc("tsd stat", FSR_DEV_FAULT_B_OFS, 8'h00);
    reg_wr(FSR_RECOVER_CFG_OFS, 8'h00);
  endtask

  task automatic cd(input logic v, input logic [7:0] e);
    @(posedge clk);
    clk_detect_raw <= v;
    cyc(8);
    check("detect", {7'h00, clk_detect_status}, e);
  endtask

  task automatic t_clkdet();
    cd(1'b1, 8'h01);
    cd(1'b0, 8'h00);
    reg_wr(FSR_RECOVER_CFG_OFS, 8'h80);
    cd(1'b1, 8'h01);
    cd(1'b0, 8'h01);
    reg_wr(FSR_RECOVER_CFG_OFS, 8'h00);
    cyc(8);
    check("detect live", {7'h00, clk_detect_status}, 8'h00);
  endtask

  // Everything masked, then a reset in mid-run with faults present
  task automatic t_rerst();
    reg_wr(FSR_REPORT_MASK_OFS, 8'hFF);
    reg_wr(FSR_LATCH_CFG_OFS, 8'h00);
    reg_wr(FSR_RECOVER_CFG_OFS, 8'h90);
    det <= '1;
    cyc(8);
    check("all masked", {7'h00, fault_report}, 8'h00);
    rc("chan all", FSR_CHANNEL_OUTPUT_FAULTS_OFS, 8'h0F);
    rc("deva all", FSR_DEV_FAULT_A_OFS, 8'hC7);
    check("tsd all", {7'h00, thermal_shutdown_active}, 8'h01);
    @(posedge clk);
    det <= '0;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    cyc(2);
    check("rst report", {7'h00, fault_report}, 8'h00);
    check("rst auto", {7'h00, thermal_auto_recover_enable}, 8'h00);
    rc("rst mask", FSR_REPORT_MASK_OFS, FSR_REPORT_MASK_RST);
    rc("rst latch", FSR_LATCH_CFG_OFS, FSR_LATCH_CFG_RST);
    rc("rst recover", FSR_RECOVER_CFG_OFS, FSR_RECOVER_CFG_RST);
    rc("rst chan", FSR_CHANNEL_OUTPUT_FAULTS_OFS, 8'h00);
  endtask

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    req = '0;
    det = '0;
    therm_warn_raw = 1'b0;
    clk_detect_raw = 1'b0;
    bad_count = 0;
    checks_done = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    cyc(2);
    t_reset();
    t_faults();
    t_warn();
    t_live(8'hD8, 12'h020, FSR_DEV_FAULT_A_OFS, 8'h04);
    t_live(8'hE8, 12'h001, FSR_DEV_FAULT_B_OFS, 8'h01);
    t_recover();
    t_clkdet();
    t_rerst();
    test_done();
  end
endmodule // test_fault_status_and_reporting_regs
`default_nettype wire
